/* File: core/rbd_pkg.sv */
// Package with constants and types for the registered bus driver
package rbd_pkg;
	localparam int unsigned LANE_COUNT = 16;
	localparam int unsigned SYNC_STAGES = 3;
	localparam logic [15:0] STORE_RESET = 16'h0000;
	localparam logic [2:0] SYNC_RESET = 3'h5; // Enable off, transparent, capture clock high
	localparam logic OE_RESET_N = 1'b1;
	typedef logic [LANE_COUNT-1:0] rbd_lanes_type;
endpackage : rbd_pkg

/* File: core/rbd_sync_if.sv */
// Interface carrying synchronised control levels to the core
`timescale 1ns/1ns
interface rbd_sync_if;
	logic output_enable_n;
	logic transparent_select_n;
	logic capture_rise;
	rbd_pkg::rbd_lanes_type lane_in;
	modport src (output output_enable_n, output transparent_select_n, output capture_rise,
		output lane_in);
	modport dst (input output_enable_n, input transparent_select_n, input capture_rise,
		input lane_in);
endinterface : rbd_sync_if

/* File: core/rbd_sync.sv */
// Pin synchroniser: three flops per input, change accepted when stages two and three agree
`timescale 1ns/1ns
module rbd_sync (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Raw pins
	input wire logic output_enable_n_i,
	input wire logic transparent_select_n_i,
	input wire logic capture_clock_i,
	input wire rbd_pkg::rbd_lanes_type lane_in_i,
	// Synchronised side
	rbd_sync_if.src sync
);
	import rbd_pkg::*;
	localparam int unsigned W = LANE_COUNT + 3;
	// Capture clock rests high through reset, so a pin already high is no edge
	localparam logic [W-1:0] RST_WORD = {SYNC_RESET, STORE_RESET};
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] level;
		logic clk_prev;
	} rbd_sync_state_type;
	rbd_sync_state_type st_reg, st_next;
	logic [W-1:0] raw;
	assign raw = {output_enable_n_i, transparent_select_n_i, capture_clock_i, lane_in_i};

	// Shift chain and agreement filter
	always_comb begin
		st_next = st_reg;
		st_next.s1 = raw;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < W; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.level[i] = st_reg.s3[i];
			end
		end
		st_next.clk_prev = st_reg.level[LANE_COUNT];
	end

	// State register
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_reg <= '{s1: RST_WORD, s2: RST_WORD, s3: RST_WORD, level: RST_WORD,
				clk_prev: SYNC_RESET[0]};
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync.output_enable_n = st_reg.level[W-1];
	assign sync.transparent_select_n = st_reg.level[W-2];
	assign sync.capture_rise = st_reg.level[LANE_COUNT] & ~st_reg.clk_prev;
	assign sync.lane_in = st_reg.level[LANE_COUNT-1:0];
endmodule : rbd_sync

/* File: core/rbd_driver.sv */
// Top of the 16-bit registered bus driver with three-state outputs
// Every pin, data and control alike, passes a three-flop filter, and a change
// counts once the second and third flops agree. A pin change therefore shows
// on the lanes five clock edges later, and a pulse shorter than about two
// clock periods may be lost.
// The stage is a plain register on the system clock. Transparent mode means
// that the stored value tracks the filtered inputs on every edge, not that a
// combinational path runs from input to output; the price is the fixed lag.
// The capture clock is only a level seen through the filter, so its rising
// edge is found by comparing two filtered samples. Data should rest for six
// clocks before such a rise, so that the filtered lanes settle first.
// The filtered capture clock starts high after reset, so a clock pin that is
// already high when reset ends does not count as a rise.
// The enable leaves as a per-lane active-low drive enable; the pin ring or
// the bench model turns it into the three-state pin.
`timescale 1ns/1ns
module rbd_driver #(
	parameter int unsigned LANES = rbd_pkg::LANE_COUNT
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Control pins
	input wire logic output_enable_n_i,
	input wire logic transparent_select_n_i,
	input wire logic capture_clock_i,
	// Data lanes
	input wire rbd_pkg::rbd_lanes_type lane_in_i,
	output logic [LANES-1:0] lane_out_o,
	output logic [LANES-1:0] lane_out_oe_n_o
);
	import rbd_pkg::*;

	// ------------------------------------------------------------
	// Stage decode
	// ------------------------------------------------------------
	// Next value of one lane: follow, capture or hold
	function automatic logic rbd_lane_next(
		input logic transp_n,
		input logic rise,
		input logic cur,
		input logic din
	);
		logic nxt;
		nxt = cur;
		if (!transp_n) begin
			nxt = din;
		end else if (rise) begin
			nxt = din;
		end
		return nxt;
	endfunction : rbd_lane_next

	// Drive enable of every lane from the filtered enable level
	function automatic logic [LANES-1:0] rbd_drive_enable_n(input logic oe_n);
		return {LANES{oe_n}};
	endfunction : rbd_drive_enable_n

	// ------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------
	rbd_sync_if sync ();
	rbd_sync u_sync (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.output_enable_n_i(output_enable_n_i),
		.transparent_select_n_i(transparent_select_n_i),
		.capture_clock_i(capture_clock_i),
		.lane_in_i(lane_in_i),
		.sync(sync.src)
	);

	// ------------------------------------------------------------
	// Storage stage and output drive
	// ------------------------------------------------------------
	typedef struct packed {
		logic [LANES-1:0] store;
		logic [LANES-1:0] oe_n;
	} rbd_state_type;
	rbd_state_type st_reg, st_next;

	// Next stage value and enable
	always_comb begin
		st_next = st_reg;
		// Each lane has its own stage bit; the stage ignores the enable
		for (int i = 0; i < LANES; i++) begin
			st_next.store[i] = rbd_lane_next(sync.transparent_select_n, sync.capture_rise,
				st_reg.store[i], sync.lane_in[i]);
		end
		// Enable is registered apart from the stage
		st_next.oe_n = rbd_drive_enable_n(sync.output_enable_n);
	end

	// State register
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_reg.store <= STORE_RESET[LANES-1:0];
			st_reg.oe_n <= {LANES{OE_RESET_N}};
		end else begin
			st_reg <= st_next;
		end
	end

	// Lanes and their drive enables come straight from the register
	assign lane_out_o = st_reg.store;
	assign lane_out_oe_n_o = st_reg.oe_n;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// One clock domain; checks pause while reset is held
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	// Filtered stage modes
	sequence s_transp_rise;
		!sync.transparent_select_n && sync.capture_rise;
	endsequence

	sequence s_capture;
		sync.transparent_select_n && sync.capture_rise;
	endsequence

	sequence s_steady;
		sync.transparent_select_n && !sync.capture_rise;
	endsequence

	// Filtered enable states
	sequence s_disabled;
		sync.output_enable_n;
	endsequence

	sequence s_enable_fall;
		$fell(sync.output_enable_n) && sync.transparent_select_n && !sync.capture_rise;
	endsequence

	// Release follows a high filtered enable
	a_oe_off_release: assert property (sync.output_enable_n |=> &lane_out_oe_n_o)
		else $error("outputs driven while enable high");

	// Drive follows a low filtered enable
	a_oe_on_drive: assert property (!sync.output_enable_n |=> ~|lane_out_oe_n_o)
		else $error("outputs not driven while enable low");

	// Transparent stage tracks the filtered lanes
	a_transp_follow: assert property (!sync.transparent_select_n
		|=> lane_out_o == $past(sync.lane_in))
		else $error("transparent output does not follow input");

	// Rising capture clock loads the stage
	a_capture_load: assert property (s_capture |=> lane_out_o == $past(sync.lane_in))
		else $error("rising clock did not capture");

	// Steady clock holds the stage
	a_hold_steady: assert property (sync.transparent_select_n && !sync.capture_rise
		|=> $stable(lane_out_o))
		else $error("output changed without capture");

	// Captures still land while outputs are off
	a_store_while_off: assert property ((s_disabled and s_capture)
		|=> lane_out_o == $past(sync.lane_in))
		else $error("stage not loaded while disabled");

	// Lane zero maps straight through
	a_lane_map: assert property (!sync.transparent_select_n
		|=> lane_out_o[0] == $past(sync.lane_in[0]))
		else $error("lane zero mismatch");

	// All lanes share one enable
	a_oe_uniform: assert property (&lane_out_oe_n_o || ~|lane_out_oe_n_o)
		else $error("enables differ between lanes");

	// Capture clock rise in transparent mode changes nothing extra
	a_transp_no_clock: assert property (s_transp_rise
		|=> lane_out_o == $past(sync.lane_in))
		else $error("capture clock disturbed transparent stage");

	// Disabled stage with a steady clock keeps its contents
	a_off_hold: assert property ((s_disabled and s_steady)
		|=> $stable(lane_out_o))
		else $error("stage lost contents while disabled");

	// Re-enabling drives the kept value unchanged
	a_reenable_keep: assert property (s_enable_fall
		|=> ~|lane_out_oe_n_o && $stable(lane_out_o))
		else $error("re-enabled outputs did not show kept value");

	// Enable edges reach all lanes one edge later
	a_enable_rise: assert property ($rose(sync.output_enable_n)
		|=> &lane_out_oe_n_o)
		else $error("outputs not released after enable rise");
	a_enable_fall: assert property ($fell(sync.output_enable_n)
		|=> ~|lane_out_oe_n_o)
		else $error("outputs not driven after enable fall");

	// Drive enables never change on their own
	a_oe_follow: assert property ($changed(lane_out_oe_n_o)
		|-> lane_out_oe_n_o[0] == $past(sync.output_enable_n))
		else $error("enable changed without cause");

	// Stored value changes only by following or by a capture
	a_store_cause: assert property ($changed(lane_out_o)
		|-> !$past(sync.transparent_select_n) || $past(sync.capture_rise))
		else $error("stored value changed without cause");

	// Every lane captures its own input bit
	for (genvar g = 0; g < LANES; g++) begin : g_lane_chk
		a_lane_capture: assert property (s_capture
			|=> lane_out_o[g] == $past(sync.lane_in[g]))
			else $error("lane did not capture its own input");
	end
endmodule : rbd_driver

/* File: tb/rbd_far_end.sv */
// Far-end bus model that resolves the three-state lanes
`timescale 1ns/1ns
module rbd_far_end (
	// Driver side
	input wire logic [15:0] lane_out_i,
	input wire logic [15:0] lane_oe_n_i,
	// Resolved bus
	output logic [15:0] bus_o
);
	logic [15:0] last_reg = 16'h0000;
	// Remember the last driven level
	always @* if (!lane_oe_n_i[0]) last_reg = lane_out_i;
	// Released lanes float, so show the inverse of the last level
	assign bus_o = lane_oe_n_i[0] ? ~last_reg : lane_out_i;
endmodule : rbd_far_end

/* File: tb/rbd_driver_bench.sv */
// Testbench for the registered bus driver
`timescale 1ns/1ns
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module rbd_driver_bench;
	import rbd_pkg::*;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic oe_n = 1'b1;
	logic ts_n = 1'b0;
	logic cap = 1'b0;
	rbd_lanes_type din = 16'h0000;
	logic [15:0] dout;
	logic [15:0] doe_n;
	logic [15:0] bus;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	rbd_driver u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .output_enable_n_i(oe_n),
		.transparent_select_n_i(ts_n), .capture_clock_i(cap), .lane_in_i(din),
		.lane_out_o(dout), .lane_out_oe_n_o(doe_n));
	rbd_far_end u_far (.lane_out_i(dout), .lane_oe_n_i(doe_n), .bus_o(bus));
	// Clock and hang ceiling
	initial begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			summarize();
		end
	end
	// Drive all pins at a rising edge
	task automatic put(input logic oe, input logic ts, input logic cp, input logic [15:0] d);
		@(posedge clk_sys_i);
		oe_n <= oe;
		ts_n <= ts;
		cap <= cp;
		din <= d;
		repeat (8) @(posedge clk_sys_i);
		#10;
	endtask : put
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	// Scenarios
	task automatic t_modes();
		put(1'b1, 1'b0, 1'b0, 16'h5a5a);
		`CHK("oe_n idle", 16'hffff, doe_n)
		put(1'b0, 1'b0, 1'b0, 16'ha5a5);
		`CHK("oe_n on", 16'h0000, doe_n)
		`CHK("bus", 16'ha5a5, bus)
		put(1'b0, 1'b0, 1'b1, 16'h3c3c);
		`CHK("transp", 16'h3c3c, dout)
		$display("modes done");
	endtask : t_modes
	task automatic t_capture();
		put(1'b0, 1'b1, 1'b0, 16'h1234);
		`CHK("hold low", 16'h3c3c, dout)
		put(1'b0, 1'b1, 1'b1, 16'h1234);
		`CHK("capture", 16'h1234, dout)
		put(1'b0, 1'b1, 1'b1, 16'hffff);
		`CHK("hold high", 16'h1234, dout)
		$display("capture done");
	endtask : t_capture
	task automatic t_retain();
		put(1'b1, 1'b1, 1'b0, 16'h0f0f);
		put(1'b1, 1'b1, 1'b1, 16'h0f0f);
		`CHK("off", 16'hffff, doe_n)
		put(1'b0, 1'b1, 1'b1, 16'hf0f0);
		`CHK("kept", 16'h0f0f, dout)
		$display("retain done");
	endtask : t_retain
	// Mid-run reset with the capture clock resting high must not capture
	task automatic t_reset();
		@(posedge clk_sys_i);
		arst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#10;
		`CHK("rst store", STORE_RESET, dout)
		`CHK("rst oe_n", 16'hffff, doe_n)
		@(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		repeat (9) @(posedge clk_sys_i);
		#10;
		`CHK("no false capture", STORE_RESET, dout)
		`CHK("oe_n again", 16'h0000, doe_n)
		$display("reset done");
	endtask : t_reset
	// Main sequence
	initial begin
		repeat (20) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		t_modes();
		t_capture();
		t_retain();
		t_reset();
		summarize();
	end
endmodule : rbd_driver_bench
